/* File: shared/min_bus_pkg.sv */
// Purpose: Constants, types and decode helpers for the minimum-mode bus control block
// Assumes: 100 MHz i_mclk; processor clock is i_mclk divided by three
// Notes:   One high phase and two low phases give the 33 percent duty processor clock
//
// How it works
// - Wait instruction proceeds when wait condition is low, otherwise idles.
// - Wait condition is synchronised and sampled at each processor clock leading edge.
// - A rising edge on the nonmaskable input raises a type 2 interrupt.
// - Nonmaskable interrupt has no software mask; every detected edge is serviced unless reset clears it first.
// - Synchronised nonmaskable edge is serviced after the current instruction completes.
// - Reset abandons the current activity at once, bus cycle included.
// - Reset is synchronised; execution restarts from reset state when reset falls.
// - Mode pin high selects minimum mode and enables the minimum-mode strobes; code pulses the address latch strobe in either mode.
// - Memory/IO status high for memory, valid from preceding t4 to final t4; code sets it only at the start of t1.
// - In hold acknowledge status, write, direction and enable float at logic one.
// - Write strobe low during t2, t3 and wait states of write cycles.
// - Interrupt acknowledge strobe low during t2, t3 and wait states of acknowledge cycles.
// - Interrupt acknowledge strobe is always driven, never floated.
// - Address latch strobe pulses high in clock-low part of t1, never floated.
// - Transceiver direction high to transmit, low to receive, timed like status.
// - Transceiver enable low during memory, IO and acknowledge cycles, else high.
// - Enable low mid-t2 to mid-t4 for reads, start of t2 for writes.
// - Read strobe low in t2, t3, wait states; high in t2 until bus floated.
// - Maskable request is a level sampled at instruction end, gated by enable flag.

package min_bus_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int PHASES = 3;
	localparam logic [1:0] PH_HIGH = 2'h0;
	localparam logic [1:0] PH_MID = 2'h1;
	localparam logic [1:0] PH_LAST = 2'h2;
	localparam int SYNC_STAGES = 2;
	localparam int RESET_MIN_CLKS = 4;

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	localparam logic [7:0] NMI_TYPE = 8'h02;
	localparam logic [7:0] EXT_TYPE = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TS_IDLE = 3'b000,
		TS_T1 = 3'b001,
		TS_T2 = 3'b010,
		TS_T3 = 3'b011,
		TS_TW = 3'b100,
		TS_T4 = 3'b101,
		TS_HOLD = 3'b110
	} t_state_e;

	typedef enum logic [2:0] {
		CK_MEM_RD = 3'b000,
		CK_MEM_WR = 3'b001,
		CK_IO_RD = 3'b010,
		CK_IO_WR = 3'b011,
		CK_IRQ_ACK_STROBE_N = 3'b100
	} cyc_kind_e;

	typedef struct packed {
		logic valid;
		cyc_kind_e kind;
	} bus_req_s;

	typedef struct packed {
		logic memory_or_io_status;
		logic write_strobe_n;
		logic read_strobe_n;
		logic xcvr_direction;
		logic xcvr_enable_n;
	} pin_strobe_s;

	typedef struct packed {
		logic valid;
		logic nmi;
		logic [7:0] itype;
		logic [9:0] vec_addr;
	} irq_take_s;

	localparam pin_strobe_s PINS_IDLE = 5'h1F;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic kind_is_write(input cyc_kind_e k);
		return (k == CK_MEM_WR) || (k == CK_IO_WR);
	endfunction

	function automatic logic kind_is_mem(input cyc_kind_e k);
		return (k == CK_MEM_RD) || (k == CK_MEM_WR);
	endfunction

	function automatic logic kind_is_irq_ack_strobe_n(input cyc_kind_e k);
		return k == CK_IRQ_ACK_STROBE_N;
	endfunction

endpackage

/* File: verilog/sync2.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps

module sync2 #(
	parameter int W = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	import min_bus_pkg::*;

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	if (W < 1) begin : g_chk
		$error("sync2 width must be at least one");
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule // sync2

/* File: verilog/nmi_latch.sv */
// Purpose: Rising-edge detector and pending flag for the nonmaskable interrupt
// Assumes: i_nmi_s is already synchronised
// Notes:   A new edge in the cycle of service wins over i_take; i_clr wins over the new edge
`timescale 1ns/10ps

module nmi_latch (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_nmi_s,
	input wire logic i_take,
	input wire logic i_clr,
	output logic o_pending
);
	import min_bus_pkg::*;

	logic prev_q;
	logic pend_q;
	logic pend_d;
	wire rise = i_nmi_s & ~prev_q;

	// No mask term: every edge is kept until serviced or cleared by i_clr
	assign pend_d = i_clr ? 1'b0 : (rise | (pend_q & ~i_take));

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_q <= 1'b1;
			pend_q <= 1'b0;
		end else begin
			prev_q <= i_nmi_s;
			pend_q <= pend_d;
		end
	end

	assign o_pending = pend_q;

endmodule // nmi_latch

/* File: verilog/min_bus_ctrl.sv */
// Purpose: T-state sequencer and minimum-mode strobes of the local bus, with wait, NMI and reset pins
// Assumes: Execution unit presents bus cycle requests and instruction boundaries on i_mclk
// Notes:   All pin outputs are registered and aligned with o_cpu_clk
`timescale 1ns/10ps

module min_bus_ctrl
	import min_bus_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_reset_pin,
	input wire logic i_mode_select_pin,
	input wire logic i_wait_condition,
	input wire logic i_nonmaskable_irq,
	input wire logic i_maskable_irq_request,
	input wire logic i_ready,
	input wire logic i_hold_req,
	input wire bus_req_s i_req,
	input wire logic i_wait_insn,
	input wire logic i_insn_last,
	input wire logic i_if_flag,
	output logic o_req_ready,
	output logic o_cyc_done,
	output logic o_exec_idle,
	output irq_take_s o_irq_take,
	output logic o_core_reset,
	output logic o_restart,
	output logic o_cpu_clk,
	output pin_strobe_s o_pins,
	output logic o_pins_oe,
	output logic o_irq_ack_strobe_n,
	output logic o_addr_latch_strobe,
	output logic o_hold_ack,
	output logic o_min_mode,
	output t_state_e o_t_state
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Phase counter and strobe decode assume three mclk per processor clock
	if (PHASES != 3) begin : g_phase_chk
		$error("min_bus_ctrl needs three mclk per processor clock");
	end

	if (int'(PH_LAST) != PHASES - 1) begin : g_last_chk
		$error("last phase code does not match the phase count");
	end

	// Pin delay below is fixed at two stages by the synchroniser instances
	if (SYNC_STAGES != 2) begin : g_sync_chk
		$error("synchroniser depth is fixed at two stages");
	end

	// The reset pin must outlast its synchroniser, or a cycle might not be abandoned
	if (RESET_MIN_CLKS * PHASES <= SYNC_STAGES) begin : g_reset_chk
		$error("reset pin minimum is shorter than its synchroniser");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pins_s;
	logic rst_s;
	logic mode_s;
	logic test_s;
	logic nmi_s;
	logic maskable_irq_request_s;
	logic ready_s;
	logic hold_s;

	sync2 #(
		.W(6)
	) u_sync (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_async({i_reset_pin, i_mode_select_pin, i_wait_condition,
			i_nonmaskable_irq, i_maskable_irq_request, i_hold_req}),
		.o_sync(pins_s)
	);

	assign rst_s = pins_s[5];
	assign mode_s = pins_s[4];
	assign test_s = pins_s[3];
	assign nmi_s = pins_s[2];
	assign maskable_irq_request_s = pins_s[1];
	assign hold_s = pins_s[0];

	// Ready gets the same two stages as every other pin
	logic [0:0] ready_vec;

	sync2 #(
		.W(1)
	) u_sync_rdy (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_async(i_ready),
		.o_sync(ready_vec)
	);

	assign ready_s = ready_vec[0];

	// ----------------------------------------------------------------
	// Processor clock phases
	// ----------------------------------------------------------------
	logic [1:0] ph_q;
	logic [1:0] ph_d;
	// Phase 0 is the high third of the processor clock, phases 1 and 2 the low part
	wire ph_end = (ph_q == PH_LAST);

	assign ph_d = ph_end ? PH_HIGH : ph_q + 2'h1;

	// ----------------------------------------------------------------
	// Reset handling
	// ----------------------------------------------------------------
	logic rst_prev_q;
	wire rst_fall = rst_prev_q & ~rst_s;

	// Source holds reset at least four processor clocks, longer than the two-stage delay
	assign o_core_reset = rst_s;

	// ----------------------------------------------------------------
	// Wait instruction
	// ----------------------------------------------------------------
	logic test_q;

	assign o_exec_idle = i_wait_insn & test_q;

	// ----------------------------------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------------------------------
	t_state_e st_q;
	t_state_e st_d;
	cyc_kind_e kind_q;
	logic mio_q;
	logic dtr_q;

	// Hold is granted only between cycles, so a started transfer completes unless reset abandons it
	wire at_boundary = (st_q == TS_IDLE) || (st_q == TS_T4);
	wire hold_go = ph_end & at_boundary & hold_s & ~rst_s;
	wire accept = ph_end & at_boundary & ~hold_s & ~rst_s & i_req.valid;

	assign o_req_ready = ph_end & at_boundary & ~hold_s & ~rst_s;
	assign o_cyc_done = ph_end & (st_q == TS_T4) & ~rst_s;

	always_comb begin
		st_d = st_q;
		if (rst_s) begin
			st_d = TS_IDLE;
		end else if (ph_end) begin
			case (st_q)
				TS_IDLE: begin
					if (hold_s) begin
						st_d = TS_HOLD;
					end else if (i_req.valid) begin
						st_d = TS_T1;
					end
				end
				TS_T1: begin
					st_d = TS_T2;
				end
				TS_T2: begin
					st_d = TS_T3;
				end
				TS_T3: begin
					st_d = ready_s ? TS_T4 : TS_TW;
				end
				TS_TW: begin
					st_d = ready_s ? TS_T4 : TS_TW;
				end
				TS_T4: begin
					if (hold_s) begin
						st_d = TS_HOLD;
					end else if (i_req.valid) begin
						st_d = TS_T1;
					end else begin
						st_d = TS_IDLE;
					end
				end
				TS_HOLD: begin
					st_d = hold_s ? TS_HOLD : TS_IDLE;
				end
				default: begin
					st_d = TS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Strobe decode
	// ----------------------------------------------------------------
	// Decode works on the internal state; the output register adds one mclk
	wire in_cyc = (st_q == TS_T1) || (st_q == TS_T2) || (st_q == TS_T3) || (st_q == TS_TW) || (st_q == TS_T4);
	wire act_mid = (st_q == TS_T3) || (st_q == TS_TW);
	wire is_wr = kind_is_write(kind_q);
	wire is_ia = kind_is_irq_ack_strobe_n(kind_q);
	wire is_rd = ~is_wr & ~is_ia;
	wire t2_late = (st_q == TS_T2) && (ph_q != PH_HIGH);
	wire wr_act = is_wr & ((st_q == TS_T2) | act_mid);
	wire rd_act = is_rd & (t2_late | act_mid);
	wire ia_act = is_ia & ((st_q == TS_T2) | act_mid);
	wire den_t2 = (st_q == TS_T2) && (is_wr || (ph_q != PH_HIGH));
	wire den_t4 = (st_q == TS_T4) && (ph_q == PH_HIGH);
	wire den_act = in_cyc & (den_t2 | act_mid | den_t4);
	wire ale_act = (st_q == TS_T1) && (ph_q != PH_HIGH);
	wire float_now = (st_q == TS_HOLD) | ~mode_s;

	pin_strobe_s pins_d;

	always_comb begin
		pins_d = PINS_IDLE;
		// Hold and maximum mode both float the group, so it must read as logic one
		if (!float_now) begin
			pins_d.memory_or_io_status = mio_q;
			pins_d.xcvr_direction = dtr_q;
			pins_d.write_strobe_n = ~wr_act;
			pins_d.read_strobe_n = ~rd_act;
			pins_d.xcvr_enable_n = ~den_act;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt service at instruction boundary
	// ----------------------------------------------------------------
	logic nmi_pend;
	// A pending nonmaskable edge always beats the maskable request
	wire take_nmi = i_insn_last & nmi_pend & ~rst_s;
	wire take_ext = i_insn_last & ~nmi_pend & maskable_irq_request_s & i_if_flag & ~rst_s;
	irq_take_s irq_d;

	nmi_latch u_nmi (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_nmi_s(nmi_s),
		.i_take(take_nmi),
		.i_clr(rst_s),
		.o_pending(nmi_pend)
	);

	always_comb begin
		irq_d = '0;
		irq_d.valid = take_nmi | take_ext;
		irq_d.nmi = take_nmi;
		irq_d.itype = take_nmi ? NMI_TYPE : EXT_TYPE;
		irq_d.vec_addr = {irq_d.itype, 2'b00};
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ph_q <= PH_HIGH;
			st_q <= TS_IDLE;
			kind_q <= CK_MEM_RD;
			mio_q <= 1'b1;
			dtr_q <= 1'b1;
			test_q <= 1'b1;
			rst_prev_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			st_q <= st_d;
			rst_prev_q <= rst_s;
			if (ph_q == PH_HIGH) begin
				test_q <= test_s;
			end
			if (accept) begin
				kind_q <= i_req.kind;
				mio_q <= kind_is_mem(i_req.kind);
				dtr_q <= kind_is_write(i_req.kind);
			end
		end
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// Pin outputs, one mclk behind the decode, aligned with the processor clock
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pins <= PINS_IDLE;
			o_pins_oe <= 1'b0;
			o_irq_ack_strobe_n <= 1'b1;
			o_addr_latch_strobe <= 1'b0;
			o_cpu_clk <= 1'b1;
			o_hold_ack <= 1'b0;
			o_min_mode <= 1'b0;
			o_t_state <= TS_IDLE;
			o_irq_take <= '0;
			o_restart <= 1'b0;
		end else begin
			o_pins <= pins_d;
			o_pins_oe <= ~float_now;
			o_irq_ack_strobe_n <= ~(ia_act & mode_s);
			o_addr_latch_strobe <= ale_act;
			o_cpu_clk <= (ph_q == PH_HIGH);
			o_hold_ack <= (st_q == TS_HOLD) | hold_go;
			o_min_mode <= mode_s;
			o_t_state <= st_q;
			o_irq_take <= irq_d;
			o_restart <= rst_fall;
		end
	end

endmodule // min_bus_ctrl

/* File: bench/min_bus_ctrl_properties.sv */
// Purpose: Concurrent checks on the minimum-mode bus pins
// Assumes: Strobes lag the T-state register by at most one mclk
// Notes:   Bound to every min_bus_ctrl instance
`timescale 1ns/10ps

module min_bus_ctrl_properties
	import min_bus_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire bus_req_s i_req,
	input wire logic i_insn_last,
	input wire logic o_req_ready,
	input wire logic o_cyc_done,
	input wire irq_take_s o_irq_take,
	input wire logic o_cpu_clk,
	input wire pin_strobe_s o_pins,
	input wire logic o_pins_oe,
	input wire logic o_irq_ack_strobe_n,
	input wire logic o_addr_latch_strobe,
	input wire logic o_min_mode,
	input wire t_state_e o_t_state
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	t_state_e prev_q;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) prev_q <= TS_IDLE;
		else prev_q <= o_t_state;
	end
	wire logic in_xfer = (o_t_state inside {TS_T2, TS_T3, TS_TW}) || (prev_q inside {TS_T2, TS_T3, TS_TW});
	wire logic in_t4 = (o_t_state == TS_T4) || (prev_q == TS_T4);
	a_float_level_one: assert property (!o_pins_oe |-> o_pins == PINS_IDLE) else $error("floated pins not one");
	a_max_mode_float: assert property (!o_min_mode |-> !o_pins_oe) else $error("strobes driven in max mode");
	a_write_in_xfer: assert property (!o_pins.write_strobe_n |-> in_xfer) else $error("write strobe outside t2-tw");
	a_read_in_xfer: assert property (!o_pins.read_strobe_n |-> in_xfer) else $error("read strobe outside t2-tw");
	a_ack_in_xfer: assert property (!o_irq_ack_strobe_n |-> in_xfer) else $error("ack strobe outside t2-tw");
	a_enable_window: assert property (!o_pins.xcvr_enable_n |-> in_xfer || in_t4) else $error("enable outside cycle");
	a_latch_clock_low: assert property (
		o_addr_latch_strobe |-> !o_cpu_clk && (o_t_state == TS_T1 || prev_q == TS_T1))
		else $error("latch strobe outside t1 low");
	a_accept_starts_t1: assert property (
		i_req.valid && o_req_ready |=> ##1 o_t_state == TS_T1 ##[0:3] o_addr_latch_strobe)
		else $error("accepted cycle without t1 latch pulse");
	a_wait_after_t3: assert property ($rose(o_t_state == TS_TW) |-> $past(o_t_state) == TS_T3)
		else $error("wait state not after t3");
	a_done_ends_t4: assert property (
		o_cyc_done |-> o_t_state == TS_T4 ##1 o_t_state == TS_T4 ##1 o_t_state != TS_T4)
		else $error("done outside last t4 mclk");
	a_status_steady: assert property (o_pins_oe && (o_t_state inside {TS_T3, TS_TW}) |->
		$stable(o_pins.memory_or_io_status) && $stable(o_pins.xcvr_direction)) else $error("status moved mid cycle");
	a_nmi_type_two: assert property (o_irq_take.valid && o_irq_take.nmi |->
		o_irq_take.itype == NMI_TYPE && o_irq_take.vec_addr == 10'h008 && $past(i_insn_last))
		else $error("bad nonmaskable take");
endmodule // min_bus_ctrl_properties

bind min_bus_ctrl min_bus_ctrl_properties u_props (.i_mclk, .i_rst_b, .i_req, .i_insn_last, .o_req_ready,
	.o_cyc_done, .o_irq_take, .o_cpu_clk, .o_pins, .o_pins_oe, .o_irq_ack_strobe_n, .o_addr_latch_strobe,
	.o_min_mode, .o_t_state);

/* File: bench/bus_target_model.sv */
// Purpose: Memory or I/O target that answers strobes with ready
// Assumes: i_waits is held steady through a cycle
// Notes:   Ready stays low while no strobe selects the target
`timescale 1ns/10ps

module bus_target_model
	import min_bus_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire pin_strobe_s i_pins,
	input wire logic i_irq_ack_strobe_n,
	input wire logic [1:0] i_waits,
	output logic o_ready
);
	logic [4:0] cnt_q;
	wire logic sel = !i_pins.read_strobe_n || !i_pins.write_strobe_n || !i_irq_ack_strobe_n;
	// Saturating count, so ready cannot drop back while a strobe is still low
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) cnt_q <= 5'h00;
		else cnt_q <= sel ? ((cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01) : 5'h00;
	end
	// Six mclk of delay per wait step so each step surely costs wait states
	assign o_ready = sel && (cnt_q >= 5'(6 * i_waits));
endmodule // bus_target_model

/* File: bench/min_bus_ctrl_tb.sv */
// Purpose: Self-checking bench for the minimum-mode bus control block
// Assumes: Inputs change on the falling edge of i_mclk
// Notes:   Random bus cycles plus reset, hold, interrupt and mode corners
`timescale 1ns/10ps

module min_bus_ctrl_tb;
	import min_bus_pkg::*;
	logic i_mclk = 0, i_rst_b = 0, i_reset_pin = 0, i_mode_select_pin = 1, i_wait_condition = 0;
	logic i_nonmaskable_irq = 0, i_maskable_irq_request = 0, i_hold_req = 0, i_wait_insn = 0;
	logic i_insn_last = 0, i_if_flag = 0, i_ready;
	bus_req_s i_req = '0;
	logic [1:0] waits = 2'h0;
	logic o_req_ready, o_cyc_done, o_exec_idle, o_core_reset, o_restart, o_cpu_clk, o_pins_oe;
	logic o_irq_ack_strobe_n, o_addr_latch_strobe, o_hold_ack, o_min_mode;
	irq_take_s o_irq_take;
	pin_strobe_s o_pins;
	t_state_e o_t_state;
	int bad_count = 0, comparisons = 0, n;
	integer seed = 3700;

	min_bus_ctrl DUT (.i_mclk, .i_rst_b, .i_reset_pin, .i_mode_select_pin, .i_wait_condition, .i_nonmaskable_irq,
		.i_maskable_irq_request, .i_ready, .i_hold_req, .i_req, .i_wait_insn, .i_insn_last, .i_if_flag,
		.o_req_ready, .o_cyc_done, .o_exec_idle, .o_irq_take, .o_core_reset, .o_restart, .o_cpu_clk, .o_pins,
		.o_pins_oe, .o_irq_ack_strobe_n, .o_addr_latch_strobe, .o_hold_ack, .o_min_mode, .o_t_state);
	bus_target_model u_target (.i_mclk, .i_rst_b, .i_pins(o_pins), .i_irq_ack_strobe_n(o_irq_ack_strobe_n), .i_waits(waits),
		.o_ready(i_ready));

	initial begin
		forever #5 i_mclk = ~i_mclk;
	end

	// ----------------------------------------------------------------
	// Checks and expectations
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Strobe low counts in mclk, latch pulses, status and direction
	function automatic logic [47:0] exp_pins(input cyc_kind_e k, input int tw);
		logic wk, ik, mk;
		logic [7:0] b;
		wk = (k == CK_MEM_WR) || (k == CK_IO_WR);
		ik = (k == CK_IRQ_ACK_STROBE_N);
		mk = (k == CK_MEM_RD) || (k == CK_MEM_WR);
		b = 8'(6 + tw);
		return {wk ? b : 8'h00, (wk || ik) ? 8'h00 : b - 8'h01, ik ? b : 8'h00, wk ? b + 8'h01 : b, 8'h02, 6'h00, mk, wk};
	endfunction

	task automatic issue(input cyc_kind_e k);
		i_req = '{1'b1, k};
		n = 0;
		while (o_req_ready !== 1'b1 && n < 60) begin
			@(negedge i_mclk);
			n++;
		end
		if (n >= 60) bad_count++;
		@(negedge i_mclk);
		i_req.valid = 1'b0;
	endtask

	task automatic do_cycle(input cyc_kind_e k, input logic [1:0] w);
		int post, tw;
		logic [7:0] wr, rd, ia, de, al;
		logic st, dr;
		post = 0; tw = 0; wr = 0; rd = 0; ia = 0; de = 0; al = 0; st = 0; dr = 0;
		waits = w;
		issue(k);
		n = 0;
		while (post < 3 && n < 200) begin
			wr += 8'(o_pins.write_strobe_n === 1'b0);
			rd += 8'(o_pins.read_strobe_n === 1'b0);
			ia += 8'(o_irq_ack_strobe_n === 1'b0);
			de += 8'(o_pins.xcvr_enable_n === 1'b0);
			if (o_addr_latch_strobe === 1'b1) begin
				al++;
				st = o_pins.memory_or_io_status;
				dr = o_pins.xcvr_direction;
			end
			tw += int'(o_t_state === TS_TW);
			if (o_cyc_done === 1'b1 || post > 0) post++;
			n++;
			@(negedge i_mclk);
		end
		chk_flag(tw != 0, w != 0);
		chk_val({wr, rd, ia, de, al, 6'h00, st, dr}, exp_pins(k, tw));
	endtask

	task automatic take_irq(input logic exp_v, input logic exp_nmi, input logic [7:0] exp_t);
		i_insn_last = 1'b1;
		@(negedge i_mclk);
		i_insn_last = 1'b0;
		chk_val({38'h0, o_irq_take.valid, exp_v ? {o_irq_take.nmi, o_irq_take.itype} : 9'h000},
			{38'h0, exp_v, exp_nmi, exp_t});
		@(negedge i_mclk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge i_mclk);
		@(negedge i_mclk);
		i_rst_b = 1'b1;
		repeat (6) @(negedge i_mclk);
		for (int i = 0; i < 5; i++) do_cycle(cyc_kind_e'(i), 2'h0);
		for (int i = 0; i < 30; i++) do_cycle(cyc_kind_e'(3'($unsigned($random(seed)) % 5)), 2'($unsigned($random(seed)) % 3));
		issue(CK_MEM_WR);
		repeat (4) @(negedge i_mclk);
		i_reset_pin = 1'b1;
		repeat (6) @(negedge i_mclk);
		chk_val({40'h0, o_t_state, o_pins}, {40'h0, TS_IDLE, PINS_IDLE});
		chk_flag(o_core_reset, 1'b1);
		repeat (9) @(negedge i_mclk);
		i_reset_pin = 1'b0;
		n = 0;
		while (o_restart !== 1'b1 && n < 12) begin
			@(negedge i_mclk);
			n++;
		end
		chk_flag(o_restart, 1'b1);
		chk_flag(o_core_reset, 1'b0);
		repeat (6) @(negedge i_mclk);
		i_nonmaskable_irq = 1'b1;
		repeat (6) @(negedge i_mclk);
		take_irq(1'b1, 1'b1, NMI_TYPE);
		i_nonmaskable_irq = 1'b0;
		i_maskable_irq_request = 1'b1;
		repeat (4) @(negedge i_mclk);
		take_irq(1'b0, 1'b0, 8'h00);
		i_if_flag = 1'b1;
		take_irq(1'b1, 1'b0, EXT_TYPE);
		i_maskable_irq_request = 1'b0;
		i_wait_insn = 1'b1;
		i_wait_condition = 1'b1;
		repeat (8) @(negedge i_mclk);
		chk_flag(o_exec_idle, 1'b1);
		i_wait_condition = 1'b0;
		repeat (8) @(negedge i_mclk);
		chk_flag(o_exec_idle, 1'b0);
		i_wait_insn = 1'b0;
		i_hold_req = 1'b1;
		n = 0;
		while (o_hold_ack !== 1'b1 && n < 30) begin
			@(negedge i_mclk);
			n++;
		end
		@(negedge i_mclk);
		chk_val({41'h0, o_pins_oe, o_irq_ack_strobe_n, o_pins}, {41'h0, 1'b0, 1'b1, PINS_IDLE});
		chk_flag(o_req_ready, 1'b0);
		i_hold_req = 1'b0;
		repeat (10) @(negedge i_mclk);
		do_cycle(CK_IO_WR, 2'h1);
		i_mode_select_pin = 1'b0;
		repeat (8) @(negedge i_mclk);
		chk_flag(o_pins_oe, 1'b0);
		i_mode_select_pin = 1'b1;
		repeat (8) @(negedge i_mclk);
		chk_flag(o_pins_oe, 1'b1);
		report_and_stop();
	end

	initial begin
		#400000;
		bad_count++;
		report_and_stop();
	end
endmodule // min_bus_ctrl_tb
